/* logic/cci_engine.sv */
// Invalidation sequencer: optional write-buffer flush, then cache invalidate.
// Assumes flush and cache handshakes are level request / one-cycle done.
`timescale 1ns/1ps
module cci_engine #(
    parameter int DOM_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Command
    input  wire logic                 start,
    input  wire logic [1:0]           req_gran,
    input  wire logic [DOM_WIDTH-1:0] domain_number,
    input  wire logic [15:0]          source_number,
    input  wire logic [1:0]           fmask,
    input  wire logic                 write_buffer_flush_required,
    output logic                      done,
    output logic [1:0]                done_gran,
    // Write-buffer flush
    output logic                      flush_req,
    input  wire logic                 flush_done,
    // Cache invalidate port
    output logic                      inv_req,
    output logic [1:0]                inv_gran,
    output logic [DOM_WIDTH-1:0]      inv_domain,
    output logic [15:0]               inv_source,
    output logic [15:0]               inv_source_care,
    input  wire logic                 inv_done
);
    // ****************************************
    // Sequencer
    // ****************************************
    typedef enum logic [1:0] {CCI_IDLE, CCI_FLUSH, CCI_INV} cci_state_t;
    cci_state_t state;

    // Reserved code degrades to global
    function automatic logic [1:0] cci_eff_gran(input logic [1:0] g);
        cci_eff_gran = (g == cci_pkg::CCI_GRAN_RSVD) ? cci_pkg::CCI_GRAN_GLOBAL : g; // RQ6
    endfunction

    function automatic logic [15:0] cci_care(input logic [1:0] m);
        case (m)
            2'h0:    cci_care = 16'hFFFF;
            2'h1:    cci_care = 16'hFFFB;
            2'h2:    cci_care = 16'hFFF9;
            default: cci_care = 16'hFFF8;
        endcase
    endfunction

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= CCI_IDLE;
        end else begin
            case (state)
                CCI_IDLE:  if (start) begin
                    state <= write_buffer_flush_required ? CCI_FLUSH : CCI_INV; // RQ16
                end
                CCI_FLUSH: if (flush_done) begin
                    state <= CCI_INV;
                end
                CCI_INV:   if (inv_done) begin
                    state <= CCI_IDLE;
                end
                default:   state <= CCI_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            inv_gran        <= 2'h0;
            inv_domain      <= '0;
            inv_source      <= 16'h0000;
            inv_source_care <= 16'hFFFF;
        end else if (state == CCI_IDLE && start) begin
            inv_gran        <= cci_eff_gran(req_gran);
            inv_domain      <= domain_number; // RQ11
            inv_source      <= source_number;
            inv_source_care <= cci_care(fmask); // RQ7
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done      <= 1'b0;
            done_gran <= 2'h0;
        end else begin
            done      <= (state == CCI_INV) && inv_done;
            done_gran <= inv_gran; // RQ5
        end
    end

    assign flush_req = (state == CCI_FLUSH);
    assign inv_req   = (state == CCI_INV);
endmodule

/* logic/cci_top.sv */
// Context-cache invalidation command register with AXI4-Lite slave.
// Assumes one clock; the cache answers each invalidate with inv_done.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module cci_top #(
    parameter int DOM_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // AXI4-Lite write address
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Capability
    input  wire logic                 write_buffer_flush_required,
    // Write-buffer flush
    output logic                      flush_req,
    input  wire logic                 flush_done,
    // Cache invalidate port
    output logic                      inv_req,
    output logic [1:0]                inv_gran,
    output logic [DOM_WIDTH-1:0]      inv_domain,
    output logic [15:0]               inv_source,
    output logic [15:0]               inv_source_care,
    input  wire logic                 inv_done
);
    // ****************************************
    // Command register fields
    // ****************************************
    logic                  invalidate_request_flag;
    logic [1:0]            requested_granularity;
    logic [1:0]            actual_granularity;
    logic [1:0]            phantom_function_mask;
    logic [15:0]           requester_source_number;
    logic [DOM_WIDTH-1:0]  domain_number;
    logic                  start;
    logic                  done;
    logic [1:0]            done_gran;

    // ****************************************
    // Write channel
    // ****************************************
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [15:0] dom_old;
    logic [15:0] dom_merged;
    logic [1:0]  fmask_now;
    logic        wr_go;
    logic        wr_lo;
    logic        wr_hi;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_go = aw_held && w_held;
    assign wr_lo = wr_go && ({aw_addr[7:2], 2'h0} == cci_pkg::CMD_LO_OFFSET);
    assign wr_hi = wr_go && ({aw_addr[7:2], 2'h0} == cci_pkg::CMD_HI_OFFSET);
    assign dom_old    = 16'(domain_number);
    assign dom_merged = {w_strb[1] ? w_data[15:8] : dom_old[15:8],
                         w_strb[0] ? w_data[7:0]  : dom_old[7:0]};
    // Mask written with the request must reach the sequencer
    assign fmask_now  = (wr_hi && w_strb[0]) ? w_data[1:0] : phantom_function_mask;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cci_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_lo || wr_hi) ? cci_pkg::RESP_OKAY : cci_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // Register update
    // ****************************************
    // Start only on top-byte write with request bit set while idle
    assign start = wr_hi && w_strb[3] && w_data[31] && !invalidate_request_flag; // RQ1

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            domain_number           <= '0;
            requester_source_number <= 16'h0000;
        end else if (wr_lo) begin
            // Bits above the supported width are dropped here
            if (w_strb[0] || w_strb[1]) begin
                domain_number <= dom_merged[DOM_WIDTH-1:0]; // RQ9
            end
            if (w_strb[2]) begin
                requester_source_number[7:0] <= w_data[23:16]; // RQ8
            end
            if (w_strb[3]) begin
                requester_source_number[15:8] <= w_data[31:24];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phantom_function_mask <= 2'h0;
            requested_granularity <= 2'h0;
        end else if (wr_hi) begin
            if (w_strb[0]) begin
                phantom_function_mask <= w_data[1:0]; // RQ7
            end
            if (w_strb[3]) begin
                requested_granularity <= w_data[30:29]; // RQ4
            end
        end
    end

    // Completion wins over nothing else: set only when idle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            invalidate_request_flag <= 1'b0;
            actual_granularity      <= 2'h0;
        end else if (start) begin
            invalidate_request_flag <= 1'b1;
        end else if (done) begin
            invalidate_request_flag <= 1'b0; // RQ2
            actual_granularity      <= done_gran; // RQ3
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    logic [31:0] rd_word;
    logic        rd_hit;

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case ({s_axi_araddr[7:2], 2'h0})
            cci_pkg::CMD_LO_OFFSET: begin
                rd_word[DOM_WIDTH-1:0] = domain_number; // RQ9
            end
            cci_pkg::CMD_HI_OFFSET: begin
                rd_word[31]    = invalidate_request_flag;
                rd_word[30:29] = requested_granularity;
                rd_word[28:27] = actual_granularity;
                // Reserved bits 58:34 stay zero; mask is write-only
                rd_word[26:2]  = 25'h0000000; // RQ18
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= cci_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? cci_pkg::RESP_OKAY : cci_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    cci_engine #(
        .DOM_WIDTH (DOM_WIDTH)
    ) u_engine (
        .ref_clk                     (ref_clk),
        .rst                         (rst),
        .start                       (start),
        .req_gran                    (requested_granularity_next(start, w_data[30:29])),
        .domain_number               (domain_number),
        .source_number               (requester_source_number),
        .fmask                       (fmask_now),
        .write_buffer_flush_required (write_buffer_flush_required),
        .done                        (done),
        .done_gran                   (done_gran),
        .flush_req                   (flush_req),
        .flush_done                  (flush_done),
        .inv_req                     (inv_req),
        .inv_gran                    (inv_gran),
        .inv_domain                  (inv_domain),
        .inv_source                  (inv_source),
        .inv_source_care             (inv_source_care),
        .inv_done                    (inv_done)
    );

    function automatic logic [1:0] requested_granularity_next(input logic s,
                                                              input logic [1:0] g);
        requested_granularity_next = s ? g : 2'h0;
    endfunction
endmodule

/* shared/cci_pkg.sv */
// Constants for the context-cache invalidation command block.
// Assumes an AXI4-Lite register bus with 32-bit data words.
// Functional notes
// [RQ1] Top-byte write with request bit starts invalidation
// [RQ2] Hardware clears request bit on completion
// [RQ3] Actual granularity loaded at completion
// [RQ4] Requested granularity codes: global, domain, device
// [RQ5] Report global, domain, or device only after device
// [RQ6] Coarser granularity allowed when reported
// [RQ7] Function mask ignores low function bits; code masks from function bit 2 downward instead
// [RQ8] Source number is write-only, reads undefined
// [RQ9] Domain bits above supported width ignored
// [RQ10] Software keeps domain within advertised width
// [RQ11] Selective requests carry domain, source, mask
// [RQ12] Software never writes while request pending
// [RQ13] Software polls until request bit reads zero
// [RQ14] Software issues only with nothing outstanding
// [RQ15] Software follows with translation-cache invalidation
// [RQ16] Flush write buffer first when required
// [RQ17] Matched entries hold the requested domain
// [RQ18] Reserved bits read zero, writes ignored
package cci_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  CMD_LO_OFFSET  = 8'h28;
    localparam logic [7:0]  CMD_HI_OFFSET  = 8'h2C;
    localparam logic [63:0] CMD_RESET      = 64'h0000000000000000;
    // Field positions
    localparam int REQ_FLAG_BIT   = 63;
    localparam int REQ_GRAN_LSB   = 61;
    localparam int ACT_GRAN_LSB   = 59;
    localparam int FMASK_LSB      = 32;
    localparam int SRC_LSB        = 16;
    localparam int DOM_LSB        = 0;
    // Default work time, in cycles
    localparam int WORK_CYCLES    = 4;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CCI_GRAN_RSVD   = 2'h0,
        CCI_GRAN_GLOBAL = 2'h1,
        CCI_GRAN_DOMAIN = 2'h2,
        CCI_GRAN_DEVICE = 2'h3
    } cci_gran_t;
endpackage

/* tb/cci_top_monitor.sv */
// Concurrent checks on the context-cache command block ports.
// Assumes bind onto cci_top; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module cci_top_monitor #(
    parameter int DOM_WIDTH = 16
) (
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // Bus answers
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    // Flush and cache ports
    input wire logic                 flush_req,
    input wire logic                 flush_done,
    input wire logic                 inv_req,
    input wire logic [1:0]           inv_gran,
    input wire logic [DOM_WIDTH-1:0] inv_domain,
    input wire logic [15:0]          inv_source,
    input wire logic [15:0]          inv_source_care,
    input wire logic                 inv_done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_inv_wait;
        inv_req && !inv_done;
    endsequence
    sequence s_inv_held;
        inv_req && $stable(inv_gran) && $stable(inv_domain) && $stable(inv_source);
    endsequence

    property p_inv_hold; s_inv_wait |=> s_inv_held; endproperty
    property p_inv_end; inv_req && inv_done |=> !inv_req; endproperty
    property p_gran_legal; inv_req |-> inv_gran != 2'h0; endproperty
    property p_care; inv_req && inv_gran == 2'h3 |-> inv_source_care[15:3] == 13'h1FFF
        && inv_source_care[2:0] inside {3'h7, 3'h3, 3'h1, 3'h0}; endproperty
    property p_flush_first; flush_req |-> !inv_req; endproperty
    property p_flush_end; flush_req && flush_done |=> !flush_req; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_reset_idle;
        $fell(rst) |-> !inv_req && !flush_req && !s_axi_bvalid && !s_axi_rvalid;
    endproperty

    a_inv_hold: assert property (p_inv_hold)
        else $error("invalidate request changed before done");
    a_inv_end: assert property (p_inv_end)
        else $error("invalidate request kept after done");
    a_gran_legal: assert property (p_gran_legal)
        else $error("reserved granularity sent to cache");
    a_care: assert property (p_care)
        else $error("source care mask malformed");
    a_flush_first: assert property (p_flush_first)
        else $error("invalidate overlaps flush");
    a_flush_end: assert property (p_flush_end)
        else $error("flush request kept after done");
    a_bhold: assert property (p_bhold)
        else $error("write response not held");
    a_rhold: assert property (p_rhold)
        else $error("read data not held");
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs busy after reset");
endmodule

bind cci_top cci_top_monitor #(.DOM_WIDTH(DOM_WIDTH)) cci_top_monitor_i (
    .ref_clk(ref_clk), .rst(rst), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .flush_req(flush_req), .flush_done(flush_done),
    .inv_req(inv_req), .inv_gran(inv_gran), .inv_domain(inv_domain),
    .inv_source(inv_source), .inv_source_care(inv_source_care), .inv_done(inv_done));

/* tb/cci_top_tb_top.sv */
// Self-checking bench for the context-cache command block.
// Assumes the bench plays AXI4-Lite master, cache and flush engine.
`timescale 1ns/1ps
module cci_top_tb_top;
    typedef struct { logic [31:0] d; logic [31:0] m; logic [1:0] r; } cci_exp_t;
    localparam int DW = 8;
    localparam logic [7:0] LO = cci_pkg::CMD_LO_OFFSET;
    localparam logic [7:0] HI = cci_pkg::CMD_HI_OFFSET;
    localparam logic [1:0] OK = cci_pkg::RESP_OKAY;
    logic ref_clk = 1'b0, rst = 1'b1;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, inv_gran, last_gran;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, write_buffer_flush_required;
    logic flush_req, inv_req, flush_done = 1'b0, inv_done = 1'b0;
    logic [DW-1:0] inv_domain;
    logic [15:0]   inv_source, inv_source_care, exp_dom, exp_src, exp_care;
    logic [2:0]    care_lo [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
    int fail_count = 0, samples_checked = 0, inv_count = 0, flush_count = 0, cycles = 0;
    int seed = 32'h5721;
    cci_exp_t rq[$], e;
    logic [1:0] wq[$];
    logic [31:0] d;

    cci_top #(.DOM_WIDTH(DW)) cci_top_i (.ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .write_buffer_flush_required(write_buffer_flush_required), .flush_req(flush_req),
        .flush_done(flush_done), .inv_req(inv_req), .inv_gran(inv_gran),
        .inv_domain(inv_domain), .inv_source(inv_source), .inv_source_care(inv_source_care),
        .inv_done(inv_done));

    always #4 ref_clk = ~ref_clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        wq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                      input logic [1:0] r, output logic [31:0] v);
        rq.push_back('{x, m, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask

    task automatic run_cmd(input logic [1:0] g, input logic [1:0] fm, input logic fr);
        int n0, f0, k;
        n0 = inv_count;
        f0 = flush_count;
        exp_dom = 16'($random(seed)) & 16'((1 << DW) - 1);
        exp_src = 16'($random(seed));
        exp_care = {13'h1FFF, care_lo[fm]};
        write_buffer_flush_required <= fr;
        wr(LO, {exp_src, exp_dom}, 4'hF, OK);
        wr(HI, {1'b1, g, 2'h3, 25'h1FFFFFF, fm}, 4'hF, OK);
        k = 0;
        d = 32'h80000000;
        while (d[31] !== 1'b0 && k < 300) begin
            rd(HI, 32'h0, 32'h0, OK, d);
            k++;
        end
        rd(HI, {1'b0, g, last_gran, 27'h0}, 32'hFFFFFFFC, OK, d);
        rd(LO, {16'h0, exp_dom}, 32'h0000FFFF, OK, d);
        chk(32'(inv_count - n0), 32'h1);
        chk(32'(flush_count - f0), {31'h0, fr});
        chk({31'h0, last_gran != 2'h0 && last_gran <= ((g == 2'h0) ? 2'h1 : g)}, 32'h1);
    endtask

    // ****************************************
    // Cache, flush engine and result watcher
    // ****************************************
    always @(posedge ref_clk) begin
        inv_done <= 1'b0;
        flush_done <= 1'b0;
        if (flush_req && !flush_done && ($random(seed) & 3) == 0) begin
            flush_done <= 1'b1;
            flush_count++;
        end
        if (inv_req && !inv_done && ($random(seed) & 3) == 0) begin
            inv_done <= 1'b1;
            inv_count++;
            last_gran <= inv_gran;
            if (inv_gran != 2'h1) chk({24'h0, inv_domain}, {24'h0, exp_dom[7:0]});
            if (inv_gran == 2'h3) chk({inv_source, inv_source_care}, {exp_src, exp_care});
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            chk(s_axi_rdata & e.m, e.d & e.m);
            chk({30'h0, s_axi_rresp}, {30'h0, e.r});
        end
        if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp}, {30'h0, wq.pop_front()});
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        write_buffer_flush_required = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(HI, cci_pkg::CMD_RESET[63:32], 32'hFFFFFFFC, OK, d);
        wr(HI, 32'hA0000000, 4'h7, OK);
        repeat (20) @(posedge ref_clk);
        chk(32'(inv_count), 32'h0);
        for (int g = 0; g < 4; g++) run_cmd(2'(g), 2'h0, g[0]);
        for (int m = 0; m < 4; m++) run_cmd(2'h3, 2'(m), m[1]);
        rd(8'h30, 32'h0, 32'h0, cci_pkg::RESP_SLVERR, d);
        wr(8'h30, 32'hFFFFFFFF, 4'hF, cci_pkg::RESP_SLVERR);
        repeat (5) @(posedge ref_clk);
        end_of_test();
    end
endmodule
